// File: rtl/bms_pkg.sv
package bms_pkg;

    // Special-function register addresses.
    localparam logic [7:0] PART_ID_ADDR = 8'hC2;
    localparam logic [7:0] PLL_CTRL_ADDR = 8'hC4;

    // Part identification fields; the family code value is arbitrary.
    localparam logic [3:0] FAMILY_CODE = 4'h9;
    localparam logic [3:0] REVISION_CODE = 4'h1;

    // Control register fields.
    localparam int LOCK_BIT = 6;
    localparam int DIV_MSB = 2;
    localparam logic [2:0] DIV_RESET = 3'h3;

    // PLL ratio to the 32.768 kHz reference.
    localparam logic [9:0] PLL_RATIO = 10'h180;
    localparam logic [9:0] RATIO_TOL = 10'h002;
    localparam logic [2:0] LOCK_PERIODS = 3'h4;

    // Code-space probe length, time and cycle count.
    localparam int PROBE_NS = 200;
    localparam int CLK_NS = 10;
    localparam logic [7:0] PROBE_CYCLES = 8'(PROBE_NS / CLK_NS);

    // Start-up sequence states.
    typedef enum logic [2:0] {
        BMS_STRAP = 3'b000,
        BMS_EA_SAMPLE = 3'b001,
        BMS_EA_PROBE = 3'b010,
        BMS_EA_JUDGE = 3'b011,
        BMS_RUN = 3'b100
    } bms_state_t;

    // Special-function register bus request.
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } bms_sfr_req_t;

    // Start-up mode summary.
    typedef struct packed {
        logic download;
        logic fetch_external;
        logic emulation;
        logic ready;
    } bms_mode_t;

endpackage

// File: rtl/bms_lock_mon.sv
`timescale 1ns/100ps
// Watches the PLL output against the crystal reference and reports lock.
module bms_lock_mon (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Reference and PLL ticks, one cycle each.
    input wire logic ref_tick,
    input wire logic pll_tick,
    // Lock indication.
    output logic locked
);
    import bms_pkg::*;

    logic [9:0] count;
    logic [2:0] good;
    logic in_range;

    // A period is good when its PLL tick count is within RATIO_TOL of the ratio.
    assign in_range = (count >= PLL_RATIO - RATIO_TOL) &&
                      (count <= PLL_RATIO + RATIO_TOL);

    // Counts PLL ticks in each reference period.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (ref_tick) begin
            count <= 10'(pll_tick);
        end else if (pll_tick && count != '1) begin
            count <= count + 10'h001;
        end
    end

    // Declares lock after several good periods in a row.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            good <= '0;
            locked <= 1'b0;
        end else if (ref_tick) begin
            if (!in_range) begin
                good <= '0;
                locked <= 1'b0;
            end else if (good != LOCK_PERIODS) begin
                good <= good + 3'h1;
            end else begin
                locked <= 1'b1; // [R3]
            end
        end
    end

endmodule // bms_lock_mon

// File: rtl/bms_top.sv
`timescale 1ns/100ps
// What this block does
// R1: Read-only part identification register at address C2; writes ignored.
// R2: Upper nibble of part identification holds this member's family code.
// R3: Core clock from PLL locked at 384 times 32.768 kHz reference.
// R4: Fetch strobe pin is output; sampled as input only at reset release.
// R5: Fetch strobe low at reset release selects serial download mode.
// R6: Fetch strobe not low at reset release selects normal run mode.
// R7: Outside parties must not pull fetch strobe low unless downloading.
// R8: Download image arrives over the on-chip UART from the host.
// R9: Debug mode uses exactly the same strap as serial download.
// R10: Debugger is on-chip and needs no external memory.
// R11: Firmly tied code-space pin picks internal or external program memory.
// R12: Code-space pin pulled high by resistor enables single-pin emulation.
// R13: PLL lock flag readable at bit 6 of the PLL control register.
module bms_top (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Register bus.
    input bms_pkg::bms_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // Fetch strobe pin.
    input wire logic program_fetch_strobe_n_in,
    output logic program_fetch_strobe_n_out,
    output logic program_fetch_strobe_n_oe,
    input wire logic core_fetch_strobe_n,
    // Code-space select pin.
    input wire logic code_space_select_n_in,
    output logic code_space_select_n_out,
    output logic code_space_select_n_oe,
    // Single-pin emulation link.
    input wire logic emu_tx_en,
    input wire logic emu_tx_bit,
    output logic emu_rx_bit,
    // Clock sources.
    input wire logic ref_tick,
    input wire logic pll_tick,
    output logic core_clk_en,
    // UART download stream.
    input wire logic uart_rx_valid,
    input wire logic [7:0] uart_rx_byte,
    output logic load_wr,
    output logic [15:0] load_addr,
    output logic [7:0] load_data,
    // Mode summary.
    output bms_pkg::bms_mode_t mode
);
    import bms_pkg::*;

    bms_state_t state;
    logic [7:0] probe_cnt;
    logic ea_level;
    logic probe_low;
    logic take_byte;
    logic locked;
    logic [2:0] core_div;
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Address match shared by the write and read decoders.
    function automatic logic sfr_hit(input logic [7:0] addr,
                                     input logic [7:0] target);
        return addr == target;
    endfunction

    // Builds the PLL control read value: lock flag and divider, rest zero.
    function automatic logic [7:0] pll_ctrl_word(input logic lock,
                                                  input logic [2:0] div);
        logic [7:0] word;
        word = '0;
        word[LOCK_BIT] = lock;
        word[DIV_MSB:0] = div;
        return word;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // PLL lock monitor.
    bms_lock_mon u_lock (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ref_tick(ref_tick),
        .pll_tick(pll_tick),
        .locked(locked)
    );

    // Core clock enable is the PLL tick divided by two to the divider.
    // A divider change takes effect at the next count boundary it meets.
    assign next_div_cnt = div_cnt + 8'h01;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= '0;
            core_clk_en <= 1'b0;
        end else if (pll_tick) begin
            div_cnt <= next_div_cnt;
            core_clk_en <= (next_div_cnt & ((8'h01 << core_div) - 8'h01))
                           == 8'h00; // [R3]
        end else begin
            core_clk_en <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up sequence: strap, then code-space level and probe.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= BMS_STRAP;
            probe_cnt <= '0;
            ea_level <= 1'b1;
            probe_low <= 1'b0;
            mode <= '0;
        end else begin
            case (state)
                BMS_STRAP: begin
                    // Pin read once, first edge after reset release.
                    mode.download <= !program_fetch_strobe_n_in; // [R4] [R5]
                    state <= BMS_EA_SAMPLE; // [R6] [R9]
                end
                BMS_EA_SAMPLE: begin
                    // Pin released here: a high tie and a resistor both read high.
                    ea_level <= code_space_select_n_in;
                    probe_cnt <= PROBE_CYCLES;
                    state <= code_space_select_n_in ? BMS_EA_PROBE
                                                    : BMS_EA_JUDGE;
                end
                BMS_EA_PROBE: begin
                    // Drive low against the pull to tell resistor from tie.
                    probe_cnt <= probe_cnt - 8'h01;
                    // Level seen while driving; the last probe cycle counts.
                    probe_low <= !code_space_select_n_in;
                    if (probe_cnt == 8'h01) begin
                        state <= BMS_EA_JUDGE;
                    end
                end
                BMS_EA_JUDGE: begin
                    // Low level fetches externally; never while debugging.
                    mode.fetch_external <= !ea_level &&
                                           !mode.download; // [R11] [R10]
                    // A pin that gave way to the probe has only a resistor.
                    mode.emulation <= ea_level && probe_low; // [R12]
                    mode.ready <= 1'b1;
                    state <= BMS_RUN;
                end
                BMS_RUN: begin
                    // The mode holds until the next reset.
                    state <= BMS_RUN;
                end
                default: begin
                    state <= BMS_STRAP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers: fetch strobe is an output once the strap is taken.
    assign program_fetch_strobe_n_oe = (state != BMS_STRAP); // [R4]
    // The core owns the strobe level whenever the pin is driven.
    assign program_fetch_strobe_n_out = core_fetch_strobe_n;

    // Code-space pin is driven low only by the probe or emulator.
    assign code_space_select_n_oe = (state == BMS_EA_PROBE) ||
                                    (mode.emulation && emu_tx_en); // [R12]
    assign code_space_select_n_out = (state == BMS_EA_PROBE) ? 1'b0
                                                             : emu_tx_bit;

    // Emulator receive bit comes from a flip-flop.
    // Outside emulation it idles high, the level of a quiet line.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            emu_rx_bit <= 1'b1;
        end else begin
            emu_rx_bit <= mode.emulation ? code_space_select_n_in : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Download stream: UART bytes go to program memory in order.
    // A byte counts only once the strap chose download and start-up ended.
    assign take_byte = mode.ready && mode.download && uart_rx_valid; // [R8]

    // Each taken byte is written, then the address steps to the next.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            load_wr <= 1'b0;
            load_addr <= '0;
            load_data <= '0;
        end else begin
            load_wr <= take_byte; // [R8]
            if (take_byte) begin
                load_data <= uart_rx_byte;
            end
            if (load_wr) begin
                load_addr <= load_addr + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes: only the divider field is writable.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            core_div <= DIV_RESET;
        end else if (sfr_req.wr && sfr_hit(sfr_req.addr, PLL_CTRL_ADDR)) begin
            core_div <= sfr_req.wdata[DIV_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads; identification ignores writes entirely.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= '0;
        end else if (sfr_req.rd) begin
            if (sfr_hit(sfr_req.addr, PART_ID_ADDR)) begin
                sfr_rdata <= {FAMILY_CODE, REVISION_CODE}; // [R1] [R2]
            end else if (sfr_hit(sfr_req.addr, PLL_CTRL_ADDR)) begin
                sfr_rdata <= pll_ctrl_word(locked, core_div); // [R13]
            end else begin
                sfr_rdata <= '0;
            end
        end
    end

endmodule // bms_top

// File: tb/bms_properties.sv
`timescale 1ns/100ps
// Watches the start-up block from its ports.
module bms_properties
    import bms_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic resetn,
    // Register bus.
    input bms_pkg::bms_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    // Pins.
    input wire logic program_fetch_strobe_n_in,
    input wire logic program_fetch_strobe_n_out,
    input wire logic program_fetch_strobe_n_oe,
    input wire logic core_fetch_strobe_n,
    input wire logic code_space_select_n_in,
    input wire logic code_space_select_n_out,
    input wire logic code_space_select_n_oe,
    // Download and mode.
    input wire logic uart_rx_valid,
    input wire logic load_wr,
    input bms_pkg::bms_mode_t mode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    a_id_read_value: assert property (
        sfr_req.rd && sfr_req.addr == PART_ID_ADDR
        |=> sfr_rdata == {FAMILY_CODE, REVISION_CODE})
        else $error("part id read wrong");
    a_strap_sample: assert property (
        $rose(resetn) |=> mode.download == !$past(program_fetch_strobe_n_in))
        else $error("strap not taken at release");
    a_strobe_enable: assert property (
        $rose(resetn) |-> !program_fetch_strobe_n_oe
        ##1 program_fetch_strobe_n_oe)
        else $error("strobe enable timing wrong");
    a_strap_hold: assert property (
        $past(resetn, 2) |-> $stable(mode.download))
        else $error("strap resampled in run");
    a_strobe_follow: assert property (
        program_fetch_strobe_n_oe |->
        program_fetch_strobe_n_out == core_fetch_strobe_n)
        else $error("strobe pin not core strobe");
    a_load_taken: assert property (
        mode.ready && mode.download && uart_rx_valid |=> load_wr)
        else $error("byte not loaded");
    a_load_refused: assert property (
        !(mode.ready && mode.download && uart_rx_valid) |=> !load_wr)
        else $error("load without byte");
    a_fetch_space: assert property (
        mode.ready && !mode.emulation |-> mode.fetch_external ==
        (!code_space_select_n_in && !mode.download))
        else $error("code space wrong");
    a_probe_low: assert property (
        code_space_select_n_oe && !mode.ready |-> !code_space_select_n_out)
        else $error("probe not low");
    c_download: cover property (load_wr && mode.download);
    c_emulation: cover property (mode.emulation);
    c_external: cover property (mode.fetch_external);
endmodule // bms_properties

bind bms_top bms_properties bms_properties_i (.clk_sys, .resetn, .sfr_req,
    .sfr_rdata, .program_fetch_strobe_n_in, .program_fetch_strobe_n_out,
    .program_fetch_strobe_n_oe, .core_fetch_strobe_n, .code_space_select_n_in,
    .code_space_select_n_out, .code_space_select_n_oe, .uart_rx_valid,
    .load_wr, .mode);

// File: tb/bms_host_model.sv
`timescale 1ns/100ps
// Host side: board straps and the serial download stream.
module bms_host_model (
    // Clock and board straps.
    input wire logic clk_sys,
    input wire logic jumper_on,
    input wire logic [1:0] ea_kind,
    // Device pin drivers.
    input wire logic pfs_out,
    input wire logic pfs_oe,
    input wire logic cs_out,
    input wire logic cs_oe,
    // Resolved pins and byte stream.
    output logic pfs_pin,
    output logic cs_pin,
    output logic uart_rx_valid,
    output logic [7:0] uart_rx_byte
);
    // Only the jumper pulls the strobe low; else a pull-up holds it.
    assign pfs_pin = pfs_oe ? pfs_out : !jumper_on;
    // A firm tie beats the probe; the resistor loses to it.
    assign cs_pin = ea_kind[1] ? (cs_oe ? cs_out : 1'h1) : ea_kind[0];
    ////////////////////////////////////////////////////////////
    // Sends n bytes back to back, then idles on a changed value.
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            #1;
            uart_rx_valid = 1'h1;
            uart_rx_byte = 8'(b + i);
        end
        @(posedge clk_sys);
        #1;
        uart_rx_valid = 1'h0;
        uart_rx_byte = ~uart_rx_byte;
    endtask
    // Idle stream at time zero.
    initial begin
        uart_rx_valid = 1'h0;
        uart_rx_byte = 8'h5A;
    end
endmodule // bms_host_model

// File: tb/bms_top_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for start-up mode and identification.
module bms_top_tb_top;
    import bms_pkg::*;
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    bms_sfr_req_t sfr_req = '0;
    logic core_fetch_strobe_n = 1'h1;
    logic jumper_on = 1'h0;
    logic [1:0] ea_kind = 2'h0;
    logic ref_tick = 1'h0;
    logic emu_tx_en = 1'h0;
    logic emu_tx_bit = 1'h0;
    logic pfs_in, pfs_out, pfs_oe, cs_in, cs_out, cs_oe;
    logic uart_rx_valid, load_wr, emu_rx_bit, core_clk_en;
    logic [7:0] sfr_rdata, uart_rx_byte, load_data;
    logic [15:0] load_addr;
    bms_mode_t mode;
    int failures = 0, checks_done = 0, ref_per = 384, ref_cnt = 0;
    logic [23:0] loads[$];
    bms_top bms_top_i (.clk_sys, .resetn, .sfr_req, .sfr_rdata,
        .program_fetch_strobe_n_in(pfs_in),
        .program_fetch_strobe_n_out(pfs_out),
        .program_fetch_strobe_n_oe(pfs_oe), .core_fetch_strobe_n,
        .code_space_select_n_in(cs_in), .code_space_select_n_out(cs_out),
        .code_space_select_n_oe(cs_oe), .emu_tx_en, .emu_tx_bit,
        .emu_rx_bit, .ref_tick, .pll_tick(1'h1), .core_clk_en,
        .uart_rx_valid, .uart_rx_byte, .load_wr, .load_addr, .load_data, .mode);
    bms_host_model bms_host_model_i (.clk_sys, .jumper_on, .ea_kind, .pfs_out,
        .pfs_oe, .cs_out, .cs_oe, .pfs_pin(pfs_in), .cs_pin(cs_in),
        .uart_rx_valid, .uart_rx_byte);
    ////////////////////////////////////////////////////////////
    // Clock, reference ticks every ref_per cycles, and a load recorder.
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (load_wr === 1'h1) loads.push_back({load_addr, load_data});
        #1;
        ref_cnt = (ref_cnt + 1) % ref_per;
        ref_tick = (ref_cnt == 0);
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One register access; read data stands once it returns.
    task automatic sfr(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        sfr_req = '{a, wr, !wr, d};
        @(posedge clk_sys);
        #1;
        sfr_req = '0;
    endtask
    // Reset with given straps, wait for ready, compare the mode summary.
    task automatic boot(input logic dl, input logic [1:0] ea,
                        input logic [3:0] m);
        int n = 0;
        resetn = 1'h0;
        jumper_on = dl;
        ea_kind = ea;
        repeat (20) @(posedge clk_sys);
        #1;
        resetn = 1'h1;
        while (mode.ready !== 1'h1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (mode.ready !== 1'h1) begin
            failures++;
            $display("unexpected at %0t: start-up never ready", $time);
            print_verdict();
        end
        chk(24'(mode), 24'(m));
        loads.delete();
    endtask
    // Identification, unmapped read, divider and lock flag.
    task automatic t_regs;
        int n = 0;
        sfr(1'h1, PART_ID_ADDR, 8'h00);
        sfr(1'h0, PART_ID_ADDR, 8'h00);
        chk(sfr_rdata, {FAMILY_CODE, REVISION_CODE});
        sfr(1'h0, 8'h10, 8'h00);
        chk(sfr_rdata, 8'h00);
        sfr(1'h0, PLL_CTRL_ADDR, 8'h00);
        chk(sfr_rdata, 8'(DIV_RESET));
        sfr(1'h1, PLL_CTRL_ADDR, 8'h05);
        // Divider 5 with a PLL tick every cycle: one enable per 32 cycles.
        repeat (128) begin
            @(posedge clk_sys);
            #1;
            n += core_clk_en;
        end
        chk(24'(n), 24'h4);
        repeat (8 * 384) @(posedge clk_sys);
        sfr(1'h0, PLL_CTRL_ADDR, 8'h00);
        chk(sfr_rdata, 8'(1 << LOCK_BIT) | 8'h05);
        ref_per = 300;
        repeat (3 * 384) @(posedge clk_sys);
        sfr(1'h0, PLL_CTRL_ADDR, 8'h00);
        chk(sfr_rdata, 8'h05);
        ref_per = 384;
    endtask
    // Strobe pin follows the core; later pulls and bytes are ignored.
    task automatic t_normal;
        @(posedge clk_sys);
        #1;
        core_fetch_strobe_n = 1'h0;
        jumper_on = 1'h1;
        @(negedge clk_sys);
        chk(24'({pfs_oe, pfs_in}), 24'h2);
        bms_host_model_i.send(8'hAA, 2);
        repeat (3) @(posedge clk_sys);
        #1;
        chk(24'(loads.size()), 24'h0);
        chk(24'(mode.download), 24'h0);
        core_fetch_strobe_n = 1'h1;
    endtask
    // Emulator drives the code-space pin; the device reads it back.
    task automatic t_emu;
        @(posedge clk_sys);
        #1;
        emu_tx_en = 1'h1;
        @(posedge clk_sys);
        #1;
        chk(24'({emu_rx_bit, cs_oe, cs_in}), 24'h2);
        emu_tx_bit = 1'h1;
        @(posedge clk_sys);
        #1;
        chk(24'({emu_rx_bit, cs_oe, cs_in}), 24'h7);
        emu_tx_en = 1'h0;
    endtask
    // Two back-to-back bytes land at addresses 0 and 1.
    task automatic t_load;
        bms_host_model_i.send(8'hA0, 2);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(loads.size(), 2);
        chk(loads[0], 24'h0000A0);
        chk(loads[1], 24'h0001A1);
    endtask
    initial begin
        boot(1'h0, 2'h0, 4'h5);
        t_regs();
        t_normal();
        boot(1'h1, 2'h1, 4'h9);
        t_load();
        boot(1'h0, 2'h1, 4'h1);
        boot(1'h0, 2'h2, 4'h3);
        t_emu();
        print_verdict();
    end
endmodule // bms_top_tb_top
